// file: tb/pac_capture.sv
// capture logic latching valid words off the data pins
`timescale 1ns/1ps
module pac_capture (
  input  wire logic        clk_i,
  input  wire logic [11:0] pins_i,
  input  wire logic [11:0] pins_oe_i,
  input  wire logic        valid_i,
  output logic [11:0]      word_o
);
  // no pull on the pins: an undriven pin reads as the inverse of the last word
  wire logic [11:0] level = (pins_i & pins_oe_i) | (~word_o & ~pins_oe_i);
  // power-down and recovery words are never taken
  always_ff @(posedge clk_i) if (valid_i) word_o <= level;
endmodule : pac_capture

// file: tb/pac_top_props.sv
// concurrent checks on the converter output pins
`timescale 1ns/1ps
module pac_top_props #(parameter int W = 12, DEPTH = 6) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic signed [W:0] analog_level_i,
  input wire pac_pkg::pac_input_mode_t input_mode_i,
  input wire logic output_enable_b_i,
  input wire logic power_down_pin_i,
  input wire logic [W-1:0] data_o,
  input wire logic [W-1:0] data_oe_o,
  input wire logic data_valid_o,
  input wire logic idle_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  pins_hiz_a: assert property (output_enable_b_i |-> data_oe_o == 12'h000) else $error("hiz");
  pins_drive_a: assert property (!output_enable_b_i |-> data_oe_o == 12'hFFF) else $error("drv");
  valid_gate_a: assert property (data_valid_o |-> !output_enable_b_i && !power_down_pin_i)
    else $error("gate");
  idle_hold_a: assert property (power_down_pin_i [*2] |-> idle_o) else $error("idle");
  pd_silent_a: assert property (idle_o |-> !data_valid_o) else $error("silent");
  pd_flush_a: assert property ($fell(idle_o) |-> !data_valid_o [*6]) else $error("flush");
  // word seen now was sampled seven sampling points back: it reached the pins six edges after its sampling edge
  diff_code_a: assert property (data_valid_o && !$past(input_mode_i, 7) |->
    data_o == (12'($past(analog_level_i, 7)) ^ 12'h800)) else $error("diff");
  single_code_a: assert property (data_valid_o && $past(input_mode_i, 7) |->
    data_o == (12'($past(analog_level_i, 7) >>> 1) ^ 12'h800)) else $error("single");
  cover property (data_valid_o);
  cover property ($fell(idle_o));
  cover property ($fell(output_enable_b_i) && data_valid_o);
endmodule : pac_top_props
bind pac_top pac_top_props #(.W(W), .DEPTH(DEPTH)) u_props (.*);

// file: tb/pac_top_tb.sv
// self-checking bench for the converter output control block
`timescale 1ns/1ps
module pac_top_tb;
  logic clk_i = 1'h0, rst_b_i = 1'h0, output_enable_b_i = 1'h0, power_down_pin_i = 1'h0;
  logic signed [12:0] analog_level_i = 13'h0000;
  pac_pkg::pac_input_mode_t input_mode_i = pac_pkg::PAC_IN_DIFF;
  logic [11:0] data_o, data_oe_o, cap;
  logic data_valid_o, idle_o;
  int bad_count = 0, n_checks = 0;
  // even duty, never paused: a slow clock drains the sampling charge
  always #10 clk_i = ~clk_i;
  pac_top u_dut (.*);
  pac_capture u_cap (.clk_i, .pins_i(data_o), .pins_oe_i(data_oe_o), .valid_i(data_valid_o),
    .word_o(cap));
  task automatic chk(input string s, input logic [11:0] e, g);
    n_checks++;
    if (g !== e) bad_count++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", s, e, g);
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic t_codes;
    logic [12:0] lv [5] = '{13'h1800, 13'h0000, 13'h07FF, 13'h1800, 13'h0800};
    logic [11:0] ex [5] = '{12'h000, 12'h800, 12'hFFF, 12'h400, 12'hC00};
    for (int k = 0; k < 12; k++) begin
      @(negedge clk_i);
      if (k > 6) chk("code", ex[k-7], data_o);
      analog_level_i = lv[k % 5];
      input_mode_i = pac_pkg::pac_input_mode_t'(k % 5 > 2);
    end
  endtask : t_codes
  task automatic t_oe;
    input_mode_i = pac_pkg::PAC_IN_DIFF;
    analog_level_i = 13'h0400;
    output_enable_b_i = 1'h1;
    repeat (8) @(negedge clk_i);
    chk("hiz", 12'h000, data_oe_o);
    chk("valid_off", 12'h000, 12'(data_valid_o));
    output_enable_b_i = 1'h0;
    #1 chk("kept", 12'hC00, data_o);
    chk("drive", 12'hFFF, data_oe_o);
    chk("valid_on", 12'h001, 12'(data_valid_o));
  endtask : t_oe
  task automatic t_pd;
    int n = 0;
    analog_level_i = 13'h07FF;
    power_down_pin_i = 1'h1;
    repeat (3) @(negedge clk_i);
    chk("idle", 12'h001, 12'(idle_o));
    power_down_pin_i = 1'h0;
    while (data_valid_o !== 1'h1 && n < 20) @(negedge clk_i) n++;
    chk("exit", 12'h008, 12'(n));
    @(negedge clk_i) chk("cap", 12'hFFF, cap);
  endtask : t_pd
  initial begin
    repeat (5) @(negedge clk_i);
    rst_b_i = 1'h1;
    t_codes();
    t_oe();
    t_pd();
    wrap_up();
  end
  // traffic takes about 40 cycles; the ceiling leaves wide margin
  initial begin
    repeat (500) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end
endmodule : pac_top_tb

// file: verilog/pac_pipe.sv
// fixed-latency conversion pipeline with validity tracking
`timescale 1ns/1ps
module pac_pipe #(
  parameter int W     = 12,
  parameter int DEPTH = 6
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  pac_pipe_if.pipe  p
);
  logic [W-1:0] stage_r   [DEPTH];
  logic [W-1:0] stage_nxt [DEPTH];
  logic [DEPTH-1:0] ok_r;
  logic [DEPTH-1:0] ok_nxt;

  // ==========================================================
  // next state
  always_comb begin
    stage_nxt[0] = p.sample;
    ok_nxt[0]    = !p.flush;
    for (int i = 1; i < DEPTH; i++) begin
      stage_nxt[i] = stage_r[i-1];
      ok_nxt[i]    = ok_r[i-1] && !p.flush;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) stage_r[i] <= '0;
      ok_r <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) stage_r[i] <= stage_nxt[i];
      ok_r <= ok_nxt;
    end
  end

  assign p.word    = stage_r[DEPTH-1];
  assign p.word_ok = ok_r[DEPTH-1];
endmodule : pac_pipe

// file: verilog/pac_pipe_if.sv
// carrier between the top and the conversion pipeline
`timescale 1ns/1ps
interface pac_pipe_if #(parameter int W = 12);
  logic [W-1:0] sample;
  logic         flush;
  logic [W-1:0] word;
  logic         word_ok;
  modport top  (output sample, output flush, input word, input word_ok);
  modport pipe (input sample, input flush, output word, output word_ok);
endinterface : pac_pipe_if

// file: verilog/pac_pkg.sv
// types for the pipelined converter output control block
package pac_pkg;
  typedef enum logic [1:0] {
    PAC_ST_RUN   = 2'b00,
    PAC_ST_PDOWN = 2'b01
  } pac_state_t;
  typedef enum logic {
    PAC_IN_DIFF   = 1'b0,
    PAC_IN_SINGLE = 1'b1
  } pac_input_mode_t;
endpackage : pac_pkg

// file: verilog/pac_regs.svh
// constants for the pipelined converter output control block
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH
`define PAC_DATA_W        12
`define PAC_PIPE_DEPTH    6
`define PAC_CODE_ZERO     12'h000
`define PAC_CODE_QUARTER  12'h400
`define PAC_CODE_MID      12'h800
`define PAC_CODE_3QUARTER 12'hC00
`define PAC_CODE_FULL     12'hFFF
`define PAC_PD_FILL       12'h000
`endif

// file: verilog/pac_top.sv
// digital output side of a 12-bit pipelined sampling converter
`timescale 1ns/1ps
`include "pac_regs.svh"
module pac_top #(
  parameter int W     = `PAC_DATA_W,
  parameter int DEPTH = `PAC_PIPE_DEPTH
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic signed [W:0]      analog_level_i,
  input  wire pac_pkg::pac_input_mode_t input_mode_i,
  input  wire logic                   output_enable_b_i,
  input  wire logic                   power_down_pin_i,
  output logic [W-1:0]                data_o,
  output logic [W-1:0]                data_oe_o,
  output logic                        data_valid_o,
  output logic                        idle_o
);
  // analog_level_i is the quantised difference of the analog inputs in units
  // of one code step at differential scaling; single-ended halves the gain.

  pac_pipe_if #(.W(W)) pif ();
  pac_pkg::pac_state_t state_r;
  pac_pkg::pac_state_t state_nxt;
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;
  logic         valid_r;
  logic         valid_nxt;

  // ==========================================================
  // coding: clamp signed level and add half scale
  function automatic logic [W-1:0] to_offset_binary(input logic signed [W+1:0] lvl);
    logic signed [W+1:0] hi;
    logic signed [W+1:0] lo;
    logic signed [W+1:0] v;
    hi = (W+2)'(signed'((1 << (W-1)) - 1));
    lo = -(W+2)'(signed'(1 << (W-1)));
    v  = lvl;
    if (v > hi) v = hi;
    if (v < lo) v = lo;
    return W'(v - lo);
  endfunction : to_offset_binary

  logic signed [W+1:0] scaled;
  always_comb begin
    if (input_mode_i == pac_pkg::PAC_IN_SINGLE) begin
      scaled = (W+2)'(analog_level_i >>> 1);
    end else begin
      scaled = (W+2)'(analog_level_i);
    end
  end

  // ==========================================================
  // power state
  always_comb begin
    case (state_r)
      pac_pkg::PAC_ST_RUN:
        state_nxt = power_down_pin_i ? pac_pkg::PAC_ST_PDOWN : pac_pkg::PAC_ST_RUN;
      pac_pkg::PAC_ST_PDOWN:
        state_nxt = power_down_pin_i ? pac_pkg::PAC_ST_PDOWN : pac_pkg::PAC_ST_RUN;
      default:
        state_nxt = pac_pkg::PAC_ST_RUN;
    endcase
  end

  // sampling runs regardless of output enable; power-down flushes
  assign pif.sample = to_offset_binary(scaled);
  assign pif.flush  = power_down_pin_i || (state_r == pac_pkg::PAC_ST_PDOWN);

  // six stages from the sampling edge on, so a word leaves the pipe five edges after it was taken
  pac_pipe #(.W(W), .DEPTH(DEPTH)) u_pipe (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .p       (pif.pipe)
  );

  // ==========================================================
  // output stage: register after the six latency stages
  always_comb begin
    if (power_down_pin_i) begin
      data_nxt  = `PAC_PD_FILL;
      valid_nxt = 1'b0;
    end else begin
      data_nxt  = pif.word;
      valid_nxt = pif.word_ok;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= pac_pkg::PAC_ST_RUN;
      data_r  <= '0;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      data_r  <= data_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ==========================================================
  // pins
  assign data_o       = data_r;
  assign data_oe_o    = output_enable_b_i ? '0 : '1;
  // power-down asserts combinationally so capture drops data at once
  assign data_valid_o = valid_r && !output_enable_b_i && !power_down_pin_i;
  assign idle_o       = (state_r == pac_pkg::PAC_ST_PDOWN);
endmodule : pac_top
